// ==== inc/fdc_port_pkg.sv ====
// Purpose: Shared constants and types for the floppy controller host port.
// Assumes: One 20 MHz clock; all strobes and the data bus arrive from pins.
// Notes: Status bit positions, rate register fields and reset values.
package fdc_port_pkg;

  // Handshake status register bit positions.
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_DIR_BIT = 6;
  localparam int STAT_EXEC_BIT = 5;
  localparam int STAT_BUSY_BIT = 4;

  // Rate control register fields and reset values.
  localparam int RATE_LOW_BIT = 0;
  localparam int RATE_HIGH_BIT = 1;
  localparam int NOPRECOMP_BIT = 2;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic NOPRECOMP_RESET = 1'h0;
  localparam logic [1:0] RATE_CODE_SLOW_SPIN = 2'h1;

  // Input clock selections.
  localparam logic [1:0] CLK_SEL_16M = 2'h0;
  localparam logic [1:0] CLK_SEL_32M = 2'h1;
  localparam logic [1:0] CLK_SEL_9M6 = 2'h2;

  // Counter widths and reset values.
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Idle levels of the synchronised pin group: data, cs, rd, wr, a0, dma_ack, tc, rate_reg_load_strobe, drive type.
  localparam logic [15:0] PIN_IDLE = 16'h00EA;

  typedef enum logic [1:0] {
    PH_COMMAND,
    PH_EXECUTE,
    PH_RESULT
  } phase_t;

endpackage

// ==== logic/pin_filter.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to mclk_i.
// Notes: The output moves only when the second and third stages agree.
`timescale 1ns/1ps
module pin_filter #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Raw and filtered pins.
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      stage1_reg <= IDLE;
      stage2_reg <= IDLE;
      stage3_reg <= IDLE;
      pin_o <= IDLE;
    end
    else
    begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2_reg[i] == stage3_reg[i])
          pin_o[i] <= stage3_reg[i];
      end
    end
  end

endmodule // pin_filter

// ==== logic/rate_control.sv ====
// Purpose: Write-only data rate control register and rate decode.
// Assumes: load_i is a one-cycle pulse at the trailing edge of a qualified write.
// Notes: Only bits 0 to 2 are stored; the rest of the byte is dropped.
`timescale 1ns/1ps
module rate_control (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register write.
  input wire logic load_i,
  input wire logic [7:0] data_i,
  // Configuration.
  input wire logic [1:0] clock_select_i,
  input wire logic fm_mode_i,
  input wire logic drive_type_input_i,
  input wire logic at_eisa_mode_i,
  // Rate outputs.
  output logic rate_select_low_o,
  output logic rate_select_high_o,
  output logic spindle_speed_output_o,
  output logic precomp_disable_o,
  output logic [10:0] data_rate_kbps_o
);

  logic [1:0] rate_reg;
  logic noprecomp_reg;

  // Rate in kb/s; an unlisted code falls back to the clock divided by 64.
  function automatic logic [10:0] rate_kbps(input logic [1:0] sel, input logic [1:0] code,
                                            input logic fm, input logic drv);
    logic [10:0] mfm;
    mfm = 11'h0FA;
    if (sel == fdc_port_pkg::CLK_SEL_9M6)
      mfm = (code == 2'h0) ? 11'h12C : 11'h096; // RQ21
    else if (sel == fdc_port_pkg::CLK_SEL_32M)
      mfm = (code == 2'h0) ? 11'h3E8 : 11'h1F4; // RQ18
    else if (code == 2'h0)
      mfm = 11'h1F4; // RQ17
    else if (code == 2'h1)
      mfm = drv ? 11'h12C : 11'h0FA; // RQ17
    else
      mfm = 11'h0FA; // RQ19
    return fm ? {1'h0, mfm[10:1]} : mfm;
  endfunction

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rate_reg <= fdc_port_pkg::RATE_RESET;
      noprecomp_reg <= fdc_port_pkg::NOPRECOMP_RESET;
    end
    else if (load_i) // RQ25
    begin
      rate_reg <= {data_i[fdc_port_pkg::RATE_HIGH_BIT], data_i[fdc_port_pkg::RATE_LOW_BIT]}; // RQ16
      noprecomp_reg <= data_i[fdc_port_pkg::NOPRECOMP_BIT]; // RQ20
    end
  end

  // One registered step per change keeps the rate glitch-free.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rate_select_low_o <= 1'h0;
      rate_select_high_o <= 1'h1;
      spindle_speed_output_o <= 1'h1;
      precomp_disable_o <= 1'h0;
      data_rate_kbps_o <= 11'h0FA;
    end
    else
    begin
      rate_select_low_o <= rate_reg[0];
      rate_select_high_o <= rate_reg[1];
      spindle_speed_output_o <= (rate_reg != fdc_port_pkg::RATE_CODE_SLOW_SPIN); // RQ18
      precomp_disable_o <= at_eisa_mode_i & noprecomp_reg; // RQ20
      data_rate_kbps_o <= rate_kbps(clock_select_i, rate_reg, fm_mode_i, drive_type_input_i); // RQ19
    end
  end

endmodule // rate_control

// ==== logic/fdc_host_port.sv ====
// Purpose: Host bus port of a floppy controller: phases, status, data, DMA and rate register.
// Assumes: Bus pins are asynchronous; core-side signals share mclk_i.
// Notes: Writes are taken at the trailing edge of the write strobe, reads at the leading edge.
// Functional notes
// RQ1 - Host reads status before each phase byte.
// RQ2 - Command byte accepted when ready and direction zero.
// RQ3 - Result byte offered with ready and direction one.
// RQ4 - Read-execution byte raises interrupt; read clears it.
// RQ5 - Slow host may poll ready flag instead.
// RQ6 - Write strobe clears write-execution interrupt.
// RQ7 - Host reads status to learn interrupt cause.
// RQ8 - DMA mode: requests only, no execution interrupts.
// RQ9 - DMA request drops when acknowledge goes low.
// RQ10 - Execution end raises interrupt; first result read clears.
// RQ11 - Terminal count accepted only with acknowledge active.
// RQ12 - Chip select gates programmed strobes, ignored in DMA.
// RQ13 - No new command until results all read.
// RQ14 - Status always readable; results only in result phase.
// RQ15 - Fixed byte order; phases advance automatically.
// RQ16 - Rate register loads bits 0-1 on strobe.
// RQ17 - 16 MHz rate code decode.
// RQ18 - 32 MHz decode and spindle speed output.
// RQ19 - Default rate is clock over 64, glitch-free.
// RQ20 - Bit 2 disables precompensation in AT mode.
// RQ21 - 9.6 MHz clock gives 300/150 rates.
// RQ22 - Interrupt and request tri-stated unless DMA enabled; the code tri-states them only in AT/EISA or special mode.
// RQ23 - Direction flag shows transfer direction.
// RQ24 - Execution flag set only in non-DMA execution.
// RQ25 - Rate register bits 3-7 are ignored.
`timescale 1ns/1ps
module fdc_host_port (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host bus pins.
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic a0_i,
  input wire logic dma_ack_n_i,
  input wire logic terminal_count_i,
  input wire logic rate_reg_load_strobe_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic irq_o,
  output logic irq_oe_o,
  output logic drq_o,
  output logic drq_oe_o,
  // Mode and configuration.
  input wire logic at_eisa_mode_i,
  input wire logic special_mode_i,
  input wire logic dma_enable_i,
  input wire logic dma_mode_i,
  input wire logic [1:0] clock_select_i,
  input wire logic fm_mode_i,
  input wire logic drive_type_input_i,
  input wire logic [3:0] drive_busy_i,
  // Command bytes to the formatter.
  output logic [7:0] cmd_byte_o,
  output logic cmd_byte_valid_o,
  input wire logic [3:0] cmd_len_i,
  // Execution data.
  input wire logic exec_read_i,
  input wire logic [7:0] exec_byte_i,
  input wire logic exec_byte_valid_i,
  input wire logic exec_byte_want_i,
  output logic [7:0] exec_byte_o,
  output logic exec_byte_taken_o,
  input wire logic exec_final_i,
  output logic terminal_count_o,
  // Result bytes from the formatter.
  input wire logic [3:0] res_len_i,
  input wire logic [7:0] res_byte_i,
  output logic [3:0] res_index_o,
  // Rate outputs.
  output logic rate_select_low_o,
  output logic rate_select_high_o,
  output logic spindle_speed_output_o,
  output logic precomp_disable_o,
  output logic [10:0] data_rate_kbps_o
);

  logic [15:0] pins_f;
  logic [7:0] data_f;
  logic cs_n_f, rd_n_f, wr_n_f, a0_f, dma_ack_n_f, tc_f, rate_reg_load_strobe_n_f, drv_f;
  logic rd_n_prev_reg, wr_n_prev_reg, dma_ack_n_prev_reg;
  logic wr_data_sel_reg, wr_rate_sel_reg;
  fdc_port_pkg::phase_t phase_reg;
  fdc_port_pkg::phase_t phase_next;
  logic [3:0] cmd_count_reg;
  logic ready_reg, dir_reg, exec_flag_reg, busy_reg;
  logic irq_reg, drq_reg;
  logic byte_full_reg, byte_want_reg;
  logic [7:0] exec_hold_reg;
  logic prog_sel, dma_sel, rd_fall, rd_rise, wr_fall, wr_rise, dma_ack_fall;
  logic stat_rd, data_rd, data_wr, rate_load;
  logic cmd_take, cmd_last, tc_take, exec_done, res_take, res_last;
  logic xfer_rd, xfer_wr, byte_event, in_exec, in_result;

  pin_filter #(
    .WIDTH(16),
    .IDLE(fdc_port_pkg::PIN_IDLE)
  ) u_pins (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i({data_i, cs_n_i, rd_n_i, wr_n_i, a0_i, dma_ack_n_i, terminal_count_i,
            rate_reg_load_strobe_n_i, drive_type_input_i}),
    .pin_o(pins_f)
  );

  assign {data_f, cs_n_f, rd_n_f, wr_n_f, a0_f, dma_ack_n_f, tc_f, rate_reg_load_strobe_n_f, drv_f} = pins_f;

  // Strobe edges on the filtered pins.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rd_n_prev_reg <= 1'h1;
      wr_n_prev_reg <= 1'h1;
      dma_ack_n_prev_reg <= 1'h1;
    end
    else
    begin
      rd_n_prev_reg <= rd_n_f;
      wr_n_prev_reg <= wr_n_f;
      dma_ack_n_prev_reg <= dma_ack_n_f;
    end
  end

  assign prog_sel = !cs_n_f && dma_ack_n_f; // RQ12
  assign dma_sel = !dma_ack_n_f; // RQ12
  assign rd_fall = rd_n_prev_reg && !rd_n_f;
  assign rd_rise = !rd_n_prev_reg && rd_n_f;
  assign wr_fall = wr_n_prev_reg && !wr_n_f;
  assign wr_rise = !wr_n_prev_reg && wr_n_f;
  assign dma_ack_fall = dma_ack_n_prev_reg && !dma_ack_n_f;

  // Chip select may end before the write strobe, so the target is fixed at its start.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wr_data_sel_reg <= 1'h0;
      wr_rate_sel_reg <= 1'h0;
    end
    else if (wr_fall)
    begin
      wr_data_sel_reg <= (prog_sel && a0_f) || dma_sel; // RQ12
      wr_rate_sel_reg <= !rate_reg_load_strobe_n_f && cs_n_f; // RQ16
    end
  end

  assign stat_rd = rd_fall && prog_sel && !a0_f; // RQ14
  assign data_rd = rd_fall && ((prog_sel && a0_f) || dma_sel);
  assign data_wr = wr_rise && wr_data_sel_reg;
  assign rate_load = wr_rise && wr_rate_sel_reg; // RQ16

  assign cmd_take = (phase_reg == fdc_port_pkg::PH_COMMAND) && data_wr && ready_reg && !dir_reg; // RQ2
  assign cmd_last = cmd_take && ((cmd_count_reg + 4'h1) >= cmd_len_i); // RQ15
  assign in_exec = phase_reg == fdc_port_pkg::PH_EXECUTE;
  assign in_result = phase_reg == fdc_port_pkg::PH_RESULT;
  // Terminal count ends execution only at the close of its DMA strobe, after the last byte moved.
  assign tc_take = in_exec && tc_f && !dma_ack_n_f && (rd_rise || wr_rise); // RQ11
  assign exec_done = in_exec && (tc_take || exec_final_i);
  assign res_take = in_result && data_rd && ready_reg && dir_reg; // RQ3
  assign res_last = res_take && ((res_index_o + 4'h1) >= res_len_i); // RQ13
  assign xfer_rd = in_exec && exec_read_i && data_rd && byte_full_reg;
  assign xfer_wr = in_exec && !exec_read_i && data_wr && byte_want_reg;
  assign byte_event = in_exec && (exec_byte_valid_i || exec_byte_want_i);

  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      fdc_port_pkg::PH_COMMAND:
        if (cmd_last)
          phase_next = fdc_port_pkg::PH_EXECUTE; // RQ15
      fdc_port_pkg::PH_EXECUTE:
        if (exec_done)
          phase_next = fdc_port_pkg::PH_RESULT; // RQ10
      fdc_port_pkg::PH_RESULT:
        if (res_last)
          phase_next = fdc_port_pkg::PH_COMMAND; // RQ13
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      phase_reg <= fdc_port_pkg::PH_COMMAND;
    else
      phase_reg <= phase_next;
  end

  // Byte counters for the command and result phases.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cmd_count_reg <= fdc_port_pkg::COUNT_RESET;
      res_index_o <= fdc_port_pkg::COUNT_RESET;
    end
    else
    begin
      if (cmd_last)
        cmd_count_reg <= fdc_port_pkg::COUNT_RESET;
      else if (cmd_take)
        cmd_count_reg <= cmd_count_reg + 4'h1;
      if (res_last || exec_done)
        res_index_o <= fdc_port_pkg::COUNT_RESET;
      else if (res_take)
        res_index_o <= res_index_o + 4'h1;
    end
  end

  // Command bytes go to the formatter in arrival order.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cmd_byte_o <= fdc_port_pkg::BYTE_RESET;
      cmd_byte_valid_o <= 1'h0;
    end
    else
    begin
      cmd_byte_valid_o <= cmd_take; // RQ15
      if (cmd_take)
        cmd_byte_o <= data_f;
    end
  end

  // Execution byte holding; a new byte or request wins over a same-cycle transfer.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      byte_full_reg <= 1'h0;
      byte_want_reg <= 1'h0;
      exec_hold_reg <= fdc_port_pkg::BYTE_RESET;
      exec_byte_o <= fdc_port_pkg::BYTE_RESET;
      exec_byte_taken_o <= 1'h0;
    end
    else
    begin
      if (exec_byte_valid_i)
      begin
        byte_full_reg <= 1'h1;
        exec_hold_reg <= exec_byte_i;
      end
      else if (xfer_rd || phase_next != fdc_port_pkg::PH_EXECUTE)
        byte_full_reg <= 1'h0;
      if (exec_byte_want_i)
        byte_want_reg <= 1'h1;
      else if (xfer_wr || phase_next != fdc_port_pkg::PH_EXECUTE)
        byte_want_reg <= 1'h0;
      exec_byte_taken_o <= xfer_wr;
      if (xfer_wr)
        exec_byte_o <= data_f;
    end
  end

  // Handshake status flags, shaped by the phase being entered.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ready_reg <= 1'h1;
      dir_reg <= 1'h0;
      exec_flag_reg <= 1'h0;
      busy_reg <= 1'h0;
    end
    else
    begin
      unique case (phase_next)
        fdc_port_pkg::PH_COMMAND:
        begin
          ready_reg <= !cmd_take; // RQ2
          dir_reg <= 1'h0; // RQ23
        end
        fdc_port_pkg::PH_EXECUTE:
        begin
          ready_reg <= !dma_mode_i && (byte_full_reg || byte_want_reg) && !xfer_rd && !xfer_wr;
          dir_reg <= exec_read_i; // RQ23
        end
        fdc_port_pkg::PH_RESULT:
        begin
          ready_reg <= !res_take; // RQ3
          dir_reg <= 1'h1; // RQ23
        end
      endcase
      exec_flag_reg <= (phase_next == fdc_port_pkg::PH_EXECUTE) && !dma_mode_i; // RQ24
      busy_reg <= (phase_next != fdc_port_pkg::PH_COMMAND) || cmd_take || (cmd_count_reg != 4'h0);
    end
  end

  // Interrupt sources; a set wins over a same-cycle clear.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      irq_reg <= 1'h0;
    else if (exec_done) // RQ10
      irq_reg <= 1'h1;
    else if (byte_event && !dma_mode_i) // RQ4
      irq_reg <= 1'h1;
    else if (xfer_rd) // RQ4
      irq_reg <= 1'h0;
    else if (wr_fall && in_exec && !exec_read_i) // RQ6
      irq_reg <= 1'h0;
    else if (res_take && (res_index_o == 4'h0)) // RQ10
      irq_reg <= 1'h0;
  end

  // DMA request per byte, dropped by the falling acknowledge.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      drq_reg <= 1'h0;
    else if (byte_event && dma_mode_i) // RQ8
      drq_reg <= 1'h1;
    else if (dma_ack_fall || phase_next != fdc_port_pkg::PH_EXECUTE) // RQ9
      drq_reg <= 1'h0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'h0;
      drq_o <= 1'h0;
      irq_oe_o <= 1'h0;
      drq_oe_o <= 1'h0;
      terminal_count_o <= 1'h0;
    end
    else
    begin
      irq_o <= irq_reg;
      drq_o <= drq_reg;
      irq_oe_o <= !(at_eisa_mode_i || special_mode_i) || dma_enable_i; // RQ22
      drq_oe_o <= !(at_eisa_mode_i || special_mode_i) || dma_enable_i; // RQ22
      terminal_count_o <= tc_take; // RQ11
    end
  end

  // Read data bus: driven for the whole selected read strobe.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      data_o <= fdc_port_pkg::BYTE_RESET;
      data_oe_o <= 1'h0;
    end
    else
    begin
      if (rd_n_f)
        data_oe_o <= 1'h0;
      else if (stat_rd || data_rd)
        data_oe_o <= 1'h1;
      if (stat_rd) // RQ14
        data_o <= {ready_reg, dir_reg, exec_flag_reg, busy_reg, drive_busy_i};
      else if (res_take) // RQ14
        data_o <= res_byte_i;
      else if (xfer_rd) // RQ4
        data_o <= exec_hold_reg;
    end
  end

  rate_control u_rate (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(rate_load),
    .data_i(data_f),
    .clock_select_i(clock_select_i),
    .fm_mode_i(fm_mode_i),
    .drive_type_input_i(drv_f),
    .at_eisa_mode_i(at_eisa_mode_i),
    .rate_select_low_o(rate_select_low_o),
    .rate_select_high_o(rate_select_high_o),
    .spindle_speed_output_o(spindle_speed_output_o),
    .precomp_disable_o(precomp_disable_o),
    .data_rate_kbps_o(data_rate_kbps_o)
  );

  chk_cmd_ready_dir: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ2
    cmd_take |-> ready_reg && !dir_reg) else $error("command byte taken without ready");
  chk_result_flags: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ3
    in_result && $past(in_result) && !$past(res_take)
    |-> ready_reg && dir_reg) else $error("result flags not both set");
  chk_exec_irq_set: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ4
    byte_event && !dma_mode_i |-> ##2 irq_o) else $error("execution byte gave no interrupt");
  chk_read_clears_irq: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ4
    xfer_rd && !exec_done && !byte_event |=> !irq_reg) else $error("read did not clear interrupt");
  chk_dma_no_irq: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ8
    dma_mode_i && byte_event && !irq_reg && !exec_done |=> !irq_reg ##1 drq_o) else $error("DMA byte raised interrupt");
  chk_dma_ack_drops_drq: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ9
    dma_ack_fall && !byte_event |=> !drq_reg ##1 !drq_o) else $error("request held after acknowledge");
  chk_end_irq: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ10
    exec_done |=> in_result && irq_reg) else $error("no result interrupt");
  chk_tc_needs_ack: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ11
    terminal_count_o |-> $past(!dma_ack_n_f) && $past(tc_f)) else $error("terminal count taken without ack");
  chk_no_cmd_in_result: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ13
    in_result |=> !cmd_byte_valid_o) else $error("command taken in result phase");
  chk_exec_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ24
    exec_flag_reg |-> $past(phase_next) == fdc_port_pkg::PH_EXECUTE && !$past(dma_mode_i))
    else $error("execution flag outside non-DMA execution");
  chk_oe_gating: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ22
    $past(at_eisa_mode_i) && !$past(dma_enable_i) |-> !irq_oe_o && !drq_oe_o) else $error("outputs driven without enable");

endmodule // fdc_host_port

// ==== dv/host_bus_model.sv ====
// Purpose: Host processor and DMA controller model driving the floppy port pins.
// Assumes: Eight-clock strobes and gaps outlast the pin filter.
// Notes: Pins change only just after a rising clock edge.
`timescale 1ns/1ps
module host_bus_model (
  // Clock.
  input wire logic mclk_i,
  // Bus pins towards the device.
  output logic cs_n_o = 1'h1,
  output logic rd_n_o = 1'h1,
  output logic wr_n_o = 1'h1,
  output logic a0_o = 1'h0,
  output logic dma_ack_n_o = 1'h1,
  output logic terminal_count_o = 1'h0,
  output logic rate_reg_load_strobe_n_o = 1'h1,
  output logic [7:0] data_bus_o,
  // Read data from the device.
  input wire logic [7:0] rdata_i
);
  logic [7:0] wdat = 8'h00;
  logic drive = 1'h0;

  // A released bus shows the inverse of the last byte.
  assign data_bus_o = drive ? wdat : ~wdat;

  task automatic xfer(input logic is_rd, input logic a0, input logic cs_n, input logic dma_ack_n,
    input logic rate_reg_load_strobe_n, input logic tc, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk_i);
    a0_o <= a0;
    cs_n_o <= cs_n;
    dma_ack_n_o <= dma_ack_n;
    rate_reg_load_strobe_n_o <= rate_reg_load_strobe_n;
    terminal_count_o <= tc;
    wdat <= wd;
    drive <= !is_rd;
    @(posedge mclk_i);
    rd_n_o <= !is_rd;
    wr_n_o <= is_rd;
    repeat (8) @(posedge mclk_i);
    rd = rdata_i;
    rd_n_o <= 1'h1;
    wr_n_o <= 1'h1;
    // Qualifiers outlive the strobe for the trailing edge.
    repeat (8) @(posedge mclk_i);
    cs_n_o <= 1'h1;
    dma_ack_n_o <= 1'h1;
    rate_reg_load_strobe_n_o <= 1'h1;
    terminal_count_o <= 1'h0;
    drive <= 1'h0;
  endtask
endmodule // host_bus_model

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the floppy controller host port.
// Assumes: 16 MHz rate decode unless a scenario selects another clock.
// Notes: Result bytes are C0 plus their index, so order errors show.
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cs_n_i, rd_n_i, wr_n_i, a0_i, dma_ack_n_i, terminal_count_i, rate_reg_load_strobe_n_i;
  logic [7:0] data_i, data_o, cmd_byte_o, exec_byte_o, res_byte_i;
  logic data_oe_o, irq_o, irq_oe_o, drq_o, drq_oe_o, cmd_byte_valid_o, exec_byte_taken_o;
  logic at_eisa_mode_i = 1'h0, special_mode_i = 1'h0, dma_enable_i = 1'h0, dma_mode_i = 1'h0;
  logic [1:0] clock_select_i = 2'h0;
  logic fm_mode_i = 1'h0, drive_type_input_i = 1'h0, exec_read_i = 1'h1, exec_final_i = 1'h0;
  logic exec_byte_valid_i = 1'h0, exec_byte_want_i = 1'h0, terminal_count_o;
  logic [3:0] drive_busy_i = 4'h5, cmd_len_i = 4'h2, res_len_i = 4'h2, res_index_o;
  logic [7:0] exec_byte_i = 8'h5A;
  logic rate_select_low_o, rate_select_high_o, spindle_speed_output_o, precomp_disable_o;
  logic [10:0] data_rate_kbps_o;
  logic [7:0] cmd_cnt = 8'h00, cmd_last, taken_last, tc_cnt = 8'h00;
  int num_errors = 0, cmp_count = 0;

  assign res_byte_i = {4'hC, res_index_o};
  fdc_host_port u_fdc_host_port (.mclk_i, .rst_i, .cs_n_i, .rd_n_i, .wr_n_i, .a0_i, .dma_ack_n_i,
    .terminal_count_i, .rate_reg_load_strobe_n_i, .data_i, .data_o, .data_oe_o, .irq_o, .irq_oe_o,
    .drq_o, .drq_oe_o, .at_eisa_mode_i, .special_mode_i, .dma_enable_i, .dma_mode_i, .clock_select_i,
    .fm_mode_i, .drive_type_input_i, .drive_busy_i, .cmd_byte_o, .cmd_byte_valid_o, .cmd_len_i,
    .exec_read_i, .exec_byte_i, .exec_byte_valid_i, .exec_byte_want_i, .exec_byte_o, .exec_byte_taken_o,
    .exec_final_i, .terminal_count_o, .res_len_i, .res_byte_i, .res_index_o, .rate_select_low_o,
    .rate_select_high_o, .spindle_speed_output_o, .precomp_disable_o, .data_rate_kbps_o);
  host_bus_model u_host_bus_model (.mclk_i, .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i),
    .a0_o(a0_i), .dma_ack_n_o(dma_ack_n_i), .terminal_count_o(terminal_count_i),
    .rate_reg_load_strobe_n_o(rate_reg_load_strobe_n_i), .data_bus_o(data_i), .rdata_i(data_o));

  always @(posedge mclk_i) if (cmd_byte_valid_o === 1'h1) {cmd_cnt, cmd_last} <= {cmd_cnt + 8'h01, cmd_byte_o};
  always @(posedge mclk_i) if (exec_byte_taken_o === 1'h1) taken_last <= exec_byte_o;
  always @(posedge mclk_i) if (terminal_count_o === 1'h1) tc_cnt <= tc_cnt + 8'h01;

  initial
  begin
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rd_reg(input logic a0, input logic tc, output logic [7:0] d);
    u_host_bus_model.xfer(1'h1, a0, 1'h0, 1'h1, 1'h1, tc, 8'h00, d);
  endtask

  task automatic wr_cmd(input logic [7:0] d);
    logic [7:0] st;
    rd_reg(1'h0, 1'h0, st);
    check(16'(st[7:6]), 16'h2);
    u_host_bus_model.xfer(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, d, st);
  endtask

  task automatic rd_res(input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(1'h0, 1'h0, d);
    check(16'(d[7:6]), 16'h3);
    rd_reg(1'h1, 1'h0, d);
    check(16'(d), 16'(exp));
  endtask

  task automatic dma_wr(input logic tc, input logic [7:0] d);
    logic [7:0] x;
    // Chip select inactive: acknowledge alone qualifies.
    u_host_bus_model.xfer(1'h0, 1'h0, 1'h1, 1'h0, 1'h1, tc, d, x);
  endtask

  task automatic rate_case(input logic [1:0] c, input logic f, input logic dv, input logic [7:0] w,
    input logic [15:0] k, input logic sp);
    logic [7:0] x;
    clock_select_i <= c;
    fm_mode_i <= f;
    drive_type_input_i <= dv;
    u_host_bus_model.xfer(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, w, x);
    check(16'({rate_select_high_o, rate_select_low_o}), 16'(w[1:0]));
    check(16'(data_rate_kbps_o), k);
    check(16'(spindle_speed_output_o), 16'(sp));
    check(16'(precomp_disable_o), 16'(at_eisa_mode_i & w[2]));
  endtask

  task automatic t_reset();
    logic [7:0] st;
    check(16'({rate_select_high_o, rate_select_low_o, spindle_speed_output_o}), 16'h5);
    check(16'(data_rate_kbps_o), 16'h0FA);
    check(16'({irq_o, drq_o, precomp_disable_o, data_oe_o}), 16'h0);
    rd_reg(1'h0, 1'h0, st);
    check(16'(st), 16'h85);
    at_eisa_mode_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    check(16'({irq_oe_o, drq_oe_o}), 16'h0);
    dma_enable_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    check(16'({irq_oe_o, drq_oe_o}), 16'h3);
    $display("done: reset");
  endtask

  task automatic t_rate();
    rate_case(2'h0, 1'h0, 1'h0, 8'hF8, 16'h1F4, 1'h1);
    rate_case(2'h0, 1'h1, 1'h0, 8'h04, 16'h0FA, 1'h1);
    rate_case(2'h0, 1'h0, 1'h0, 8'h01, 16'h0FA, 1'h0);
    rate_case(2'h0, 1'h0, 1'h1, 8'h01, 16'h12C, 1'h0);
    rate_case(2'h0, 1'h1, 1'h0, 8'h02, 16'h07D, 1'h1);
    rate_case(2'h1, 1'h0, 1'h0, 8'h00, 16'h3E8, 1'h1);
    rate_case(2'h1, 1'h1, 1'h0, 8'h00, 16'h1F4, 1'h1);
    rate_case(2'h1, 1'h0, 1'h0, 8'h01, 16'h1F4, 1'h0);
    rate_case(2'h1, 1'h0, 1'h0, 8'hFE, 16'h1F4, 1'h1);
    rate_case(2'h2, 1'h0, 1'h0, 8'h00, 16'h12C, 1'h1);
    rate_case(2'h2, 1'h1, 1'h0, 8'h00, 16'h096, 1'h1);
    at_eisa_mode_i <= 1'h0;
    rate_case(2'h0, 1'h0, 1'h0, 8'h06, 16'h0FA, 1'h1);
    $display("done: rate");
  endtask

  task automatic t_pio();
    logic [7:0] d;
    wr_cmd(8'h46);
    rd_reg(1'h0, 1'h0, d);
    check(16'(d), 16'h95);
    wr_cmd(8'h12);
    check(16'({cmd_cnt, cmd_last}), 16'h0212);
    @(posedge mclk_i);
    exec_byte_valid_i <= 1'h1;
    @(posedge mclk_i);
    exec_byte_valid_i <= 1'h0;
    for (int i = 0; i < 40 && irq_o !== 1'h1; i++) @(posedge mclk_i);
    check(16'(irq_o), 16'h1);
    rd_reg(1'h0, 1'h0, d);
    check(16'(d), 16'hF5);
    // Terminal count without acknowledge is ignored.
    rd_reg(1'h1, 1'h1, d);
    check(16'(d), 16'h5A);
    check(16'({irq_o, tc_cnt}), 16'h0);
    @(posedge mclk_i);
    exec_final_i <= 1'h1;
    @(posedge mclk_i);
    exec_final_i <= 1'h0;
    for (int i = 0; i < 40 && irq_o !== 1'h1; i++) @(posedge mclk_i);
    check(16'(irq_o), 16'h1);
    rd_reg(1'h0, 1'h0, d);
    check(16'(d), 16'hD5);
    u_host_bus_model.xfer(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'hEE, d);
    check(16'(cmd_cnt), 16'h2);
    rd_res(8'hC0);
    check(16'(irq_o), 16'h0);
    rd_res(8'hC1);
    rd_reg(1'h0, 1'h0, d);
    check(16'(d), 16'h85);
    $display("done: pio");
  endtask

  task automatic t_dma();
    logic [7:0] d;
    dma_mode_i <= 1'h1;
    exec_read_i <= 1'h0;
    cmd_len_i <= 4'h1;
    wr_cmd(8'h45);
    for (int n = 0; n < 2; n++)
    begin
      @(posedge mclk_i);
      exec_byte_want_i <= 1'h1;
      @(posedge mclk_i);
      exec_byte_want_i <= 1'h0;
      for (int i = 0; i < 40 && drq_o !== 1'h1; i++) @(posedge mclk_i);
      check(16'({drq_o, irq_o}), 16'h2);
      dma_wr(n[0], 8'h3C + 8'(n));
      check(16'(taken_last), 16'h3C + 16'(n));
      check(16'(tc_cnt), 16'(n));
    end
    check(16'(drq_o), 16'h0);
    check(16'(irq_o), 16'h1);
    rd_reg(1'h0, 1'h0, d);
    check(16'(d), 16'hD5);
    rd_res(8'hC0);
    rd_res(8'hC1);
    $display("done: dma");
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'h0;
    t_reset();
    t_rate();
    t_pio();
    t_dma();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    $display("timeout at %0t", $time);
    complete_run();
  end
endmodule // tb_top
